/* File: verilog/icm_monitor.sv */
// input clock monitor: loss, drift, lock loss, per-pll switchover and holdover
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps

// ************************************************************************
// per input: missing pulse and drift monitors
// ************************************************************************
module icm_input_mon #(
    parameter int COARSE_SHIFT = 4
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        clkEn,
    input  wire logic        inLvl,
    input  wire logic [1:0]  lossSel,
    input  wire logic [15:0] period,
    input  wire logic [7:0]  fineThr,
    input  wire logic [7:0]  fineHyst,
    input  wire logic [3:0]  coarseCode,
    input  wire logic [23:0] expCnt,
    input  wire logic        isGolden,
    input  wire logic        fineEnd,
    input  wire logic        coarseEnd,
    output logic             lossFlag,
    output logic             fineFlag,
    output logic             coarseFlag
);
    import icm_pkg::*;

    logic        prevLvl;
    logic        edgeSeen;
    logic [15:0] gapCnt;
    logic [4:0]  missCnt;
    logic [4:0]  missNeed;
    logic [23:0] fineCnt;
    logic [23:0] coarseCnt;
    logic [23:0] fineDiff;
    logic [23:0] coarseDiff;
    logic [23:0] coarseExp;
    logic [7:0]  clrCode;
    logic [47:0] fineOff;
    logic [47:0] fineSet;
    logic [47:0] fineClr;
    logic [47:0] coarseOff;
    logic [47:0] coarseSet;

    assign edgeSeen  = inLvl & ~prevLvl;
    assign missNeed  = 5'h02 << lossSel;                  // 2,4,8,16
    assign coarseExp = expCnt >> COARSE_SHIFT;

    // edge history
    always_ff @(posedge clk) begin
        if (srst) begin
            prevLvl <= 1'b0;
        end else if (clkEn) begin
            prevLvl <= inLvl;
        end
    end

    // missing pulse counter: a gap longer than period is one missing pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            gapCnt   <= 16'h0000;
            missCnt  <= 5'h00;
            lossFlag <= 1'b0;
        end else if (clkEn) begin
            if (edgeSeen) begin
                gapCnt   <= 16'h0000;
                missCnt  <= 5'h00;
                lossFlag <= 1'b0;
            end else if (gapCnt >= period) begin
                gapCnt <= 16'h0000;
                if (missCnt < missNeed) begin
                    missCnt <= missCnt + 5'h01;
                end
                if (missCnt + 5'h01 >= missNeed) begin
                    lossFlag <= 1'b1;
                end
            end else begin
                gapCnt <= gapCnt + 16'h0001;
            end
        end
    end

    // offset from expected count; compare in ppm without a divider
    assign fineDiff   = (fineCnt > expCnt) ? fineCnt - expCnt : expCnt - fineCnt;
    assign coarseDiff = (coarseCnt > coarseExp) ? coarseCnt - coarseExp
                                                : coarseExp - coarseCnt;
    assign clrCode    = (fineHyst >= fineThr) ? 8'h00 : fineThr - fineHyst;
    assign fineOff    = {24'h000000, fineDiff} * {24'h000000, FINE_PPM_SCALE};
    assign fineSet    = {40'h0000000000, fineThr} * {24'h000000, expCnt};
    assign fineClr    = {40'h0000000000, clrCode} * {24'h000000, expCnt};
    assign coarseOff  = {24'h000000, coarseDiff} * {24'h000000, COARSE_PPM_SCALE};
    assign coarseSet  = {44'h00000000000, coarseCode} * {24'h000000, coarseExp};

    // both windows count at once so a fast excursion shows early
    always_ff @(posedge clk) begin
        if (srst) begin
            fineCnt   <= 24'h000000;
            coarseCnt <= 24'h000000;
        end else if (clkEn) begin
            if (fineEnd) begin
                fineCnt <= {23'h000000, edgeSeen};
            end else if (edgeSeen) begin
                fineCnt <= fineCnt + 24'h000001;
            end
            if (coarseEnd) begin
                coarseCnt <= {23'h000000, edgeSeen};
            end else if (edgeSeen) begin
                coarseCnt <= coarseCnt + 24'h000001;
            end
        end
    end

    // fine drift flag with hysteresis, coarse flag without; golden clock never drifts from itself
    always_ff @(posedge clk) begin
        if (srst) begin
            fineFlag   <= 1'b0;
            coarseFlag <= 1'b0;
        end else if (clkEn) begin
            if (isGolden) begin
                fineFlag   <= 1'b0;
                coarseFlag <= 1'b0;
            end else begin
                if (fineEnd) begin
                    if (fineOff > fineSet) begin
                        fineFlag <= 1'b1;
                    end else if (fineOff < fineClr) begin
                        fineFlag <= 1'b0;
                    end
                end
                if (coarseEnd) begin
                    coarseFlag <= (coarseOff > coarseSet);
                end
            end
        end
    end
endmodule : icm_input_mon

// ************************************************************************
// per pll: priority switching and holdover history
// ************************************************************************
module icm_pll_ctrl #(
    parameter int TICK_CYC = icm_pkg::HOLD_TICK_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 clkEn,
    input  icm_pkg::icm_pll_cfg_t     cfg,
    input  wire logic [3:0]           valid,
    input  wire logic [icm_pkg::FW-1:0] freqWord,
    output icm_pkg::icm_pll_stat_t    stat,
    output logic [icm_pkg::FW-1:0]    holdFreq
);
    import icm_pkg::*;

    logic [1:0]         pick;
    logic               found;
    icm_pll_stat_t      nextStat;
    logic [31:0]        tickCnt;
    logic               tick;
    logic [FW-1:0]      hist [1<<HIST_AW];
    logic [HIST_AW-1:0] wrPtr;
    logic [HIST_AW-1:0] fill;
    logic [HIST_AW-1:0] winLen;
    logic [HIST_AW-1:0] inAge;
    logic [HIST_AW-1:0] outAge;
    logic [FW+11:0]     sum;
    logic [FW+11:0]     avg;
    icm_pll_cfg_t       cfgPrev;

    // first valid entry among the active and ranked spares
    always_comb begin
        found    = 1'b0;
        pick     = 2'b00;
        nextStat = stat;
        for (int j = 0; j < 4; j++) begin
            if (j <= int'(cfg.spares) && valid[cfg.prio[2*j +: 2]] && !found) begin
                found = 1'b1;
                pick  = cfg.prio[2*j +: 2];
            end
        end
        if (stat.holdover) begin
            if (found) begin
                nextStat.holdover = 1'b0;
                nextStat.active   = pick;
            end
        end else if (!valid[stat.active]) begin
            if (found) begin
                nextStat.active = pick;
            end else begin
                nextStat.holdover = 1'b1;
            end
        end else if (cfg.revert && valid[cfg.prio[1:0]]) begin
            nextStat.active = cfg.prio[1:0];
        end
        // non-revertive: a valid active input is kept
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stat <= '0;
        end else if (clkEn) begin
            stat <= nextStat;
        end
    end

    // history sample tick
    always_ff @(posedge clk) begin
        if (srst) begin
            tickCnt <= 32'h0000_0000;
        end else if (clkEn) begin
            tickCnt <= tick ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
        end
    end
    assign tick   = (tickCnt >= 32'(TICK_CYC - 1));
    assign winLen = HIST_AW'(1) << cfg.holdExp;
    assign inAge  = HIST_AW'(cfg.holdDelay);
    assign outAge = inAge + winLen;
    assign avg    = sum >> cfg.holdExp;

    // history buffer; no reset so it maps to memory
    always_ff @(posedge clk) begin
        if (clkEn && tick && !stat.holdover) begin
            hist[wrPtr] <= freqWord;
        end
    end

    // running sum over ages delay .. delay+window-1; restarts when holdDelay or holdExp changes
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr    <= '0;
            fill     <= '0;
            sum      <= '0;
            holdFreq <= '0;
            cfgPrev  <= '0;
        end else if (clkEn) begin
            cfgPrev <= cfg;
            if (cfgPrev.holdDelay != cfg.holdDelay || cfgPrev.holdExp != cfg.holdExp) begin
                fill <= '0;
                sum  <= '0;
            end else if (tick && !stat.holdover) begin
                wrPtr <= wrPtr + HIST_AW'(1);
                if (fill != '1) begin
                    fill <= fill + HIST_AW'(1);
                end
                sum <= sum
                     + ((fill >= inAge && inAge != '0) ? {12'h000, hist[wrPtr - inAge]} : '0)
                     - ((fill >= outAge && inAge != '0) ? {12'h000, hist[wrPtr - outAge]} : '0);
                if (fill > outAge) begin
                    holdFreq <= avg[FW-1:0];
                end
            end
        end
    end
endmodule : icm_pll_ctrl

// ************************************************************************
// top: register port, golden gate, lock loss, alert routing
// ************************************************************************
module icm_monitor #(
    parameter int FINE_GATE_EDGES = 4096,
    parameter int COARSE_SHIFT    = 4,
    parameter int HOLD_TICK       = icm_pkg::HOLD_TICK_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    clkEn,
    input  wire logic [3:0]              inClk,
    input  wire logic                    refClk,
    input  wire logic [3:0][15:0]        lockErr,
    input  wire logic [3:0][icm_pkg::FW-1:0] freqWord,
    input  wire logic [icm_pkg::AW-1:0]  regAddr,
    input  wire logic [icm_pkg::DW-1:0]  regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic [icm_pkg::DW-1:0]       regRdData,
    output icm_pkg::icm_pll_stat_t [3:0] pllStat,
    output logic [3:0][icm_pkg::FW-1:0]  holdFreq,
    output logic [3:0]                   alertPin
);
    import icm_pkg::*;

    icm_global_t         glob;
    logic [DW-1:0]       alertCfg;
    logic [3:0][DW-1:0]  inPer;
    logic [3:0][DW-1:0]  inThr;
    logic [3:0][DW-1:0]  inExp;
    icm_pll_cfg_t [3:0]  pllCfg;
    logic [3:0]          lossFlag;
    logic [3:0]          fineFlag;
    logic [3:0]          coarseFlag;
    logic [3:0]          lockLoss;
    logic [3:0]          valid;
    logic                goldLvl;
    logic                goldPrev;
    logic [15:0]         gateCnt;
    logic                fineEnd;
    logic                coarseEnd;
    logic [2:0]          llIdx;
    logic [15:0]         llSet;
    logic [15:0]         llClr;

    // register writes; one word per aligned address
    always_ff @(posedge clk) begin
        if (srst) begin
            glob     <= RST_GLOBAL;
            alertCfg <= RST_ALERT;
            for (int i = 0; i < 4; i++) begin
                inPer[i]  <= RST_INPER;
                inThr[i]  <= RST_INTHR;
                inExp[i]  <= RST_INEXP;
                pllCfg[i] <= RST_PLLCFG;
            end
        end else if (clkEn && regWr) begin
            if (regAddr == ADR_GLOBAL) glob <= regWrData;
            if (regAddr == ADR_ALERT) alertCfg <= regWrData;
            for (int i = 0; i < 4; i++) begin
                if (regAddr == ADR_INPER + AW'(4*i)) inPer[i] <= regWrData;
                if (regAddr == ADR_INTHR + AW'(4*i)) inThr[i] <= regWrData;
                if (regAddr == ADR_INEXP + AW'(4*i)) inExp[i] <= regWrData;
                if (regAddr == ADR_PLLCFG + AW'(4*i)) pllCfg[i] <= regWrData;
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= '0;
        end else if (clkEn) begin
            regRdData <= '0;
            if (regRd) begin
                if (regAddr == ADR_GLOBAL) regRdData <= glob;
                if (regAddr == ADR_ALERT) regRdData <= alertCfg;
                if (regAddr == ADR_STAT) begin
                    regRdData <= {16'h0000, lockLoss, coarseFlag, fineFlag, lossFlag};
                end
                if (regAddr == ADR_PLLSTAT) begin
                    regRdData <= {16'h0000, 1'b0, pllStat[3], 1'b0, pllStat[2],
                                  1'b0, pllStat[1], 1'b0, pllStat[0]};
                end
                for (int i = 0; i < 4; i++) begin
                    if (regAddr == ADR_INPER + AW'(4*i)) regRdData <= inPer[i];
                    if (regAddr == ADR_INTHR + AW'(4*i)) regRdData <= inThr[i];
                    if (regAddr == ADR_INEXP + AW'(4*i)) regRdData <= inExp[i];
                    if (regAddr == ADR_PLLCFG + AW'(4*i)) regRdData <= pllCfg[i];
                    if (regAddr == ADR_HOLDF + AW'(4*i)) regRdData <= holdFreq[i];
                end
            end
        end
    end

    // golden clock select and measurement gate
    assign goldLvl   = (glob.goldSel >= 3'd4) ? refClk : inClk[glob.goldSel[1:0]];
    assign fineEnd   = goldLvl && !goldPrev && (gateCnt == 16'(FINE_GATE_EDGES - 1));
    assign coarseEnd = goldLvl && !goldPrev &&
                       (gateCnt[COARSE_SHIFT-1:0] == {COARSE_SHIFT{1'b1}});

    always_ff @(posedge clk) begin
        if (srst) begin
            goldPrev <= 1'b0;
            gateCnt  <= 16'h0000;
        end else if (clkEn) begin
            goldPrev <= goldLvl;
            if (goldLvl && !goldPrev) begin
                gateCnt <= fineEnd ? 16'h0000 : gateCnt + 16'h0001;
            end
        end
    end

    // one monitor per input
    for (genvar i = 0; i < 4; i++) begin : g_in
        icm_input_mon #(
            .COARSE_SHIFT (COARSE_SHIFT)
        ) u_mon (
            .clk        (clk),
            .srst       (srst),
            .clkEn      (clkEn),
            .inLvl      (inClk[i]),
            .lossSel    (glob.lossSel),
            .period     (inPer[i][15:0]),
            .fineThr    (inThr[i][7:0]),
            .fineHyst   (inThr[i][15:8]),
            .coarseCode (inPer[i][19:16]),
            .expCnt     (inExp[i][23:0]),
            .isGolden   (glob.goldSel == 3'(i)),
            .fineEnd    (fineEnd),
            .coarseEnd  (coarseEnd),
            .lossFlag   (lossFlag[i]),
            .fineFlag   (fineFlag[i]),
            .coarseFlag (coarseFlag[i])
        );
    end

    // loss alone makes an input unusable; drift joins per pll below
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            valid[i] = !lossFlag[i];
        end
    end

    // one switch controller per pll, each with its own validity view
    for (genvar p = 0; p < 4; p++) begin : g_pll
        logic [3:0] pllValid;
        assign pllValid = valid & ~({4{pllCfg[p].trigDrift}} & (fineFlag | coarseFlag));
        icm_pll_ctrl #(
            .TICK_CYC (HOLD_TICK)
        ) u_pll (
            .clk      (clk),
            .srst     (srst),
            .clkEn    (clkEn),
            .cfg      (pllCfg[p]),
            .valid    (pllValid),
            .freqWord (freqWord[p]),
            .stat     (pllStat[p]),
            .holdFreq (holdFreq[p])
        );
    end

    // lock loss: set above the high figure, clear below the low one
    assign llIdx = (glob.llSel > 3'd4) ? 3'd4 : glob.llSel;
    assign llSet = LL_SET_TBL[llIdx];
    assign llClr = LL_CLR_TBL[llIdx];

    always_ff @(posedge clk) begin
        if (srst) begin
            lockLoss <= 4'h0;
        end else if (clkEn) begin
            for (int p = 0; p < 4; p++) begin
                if (lockErr[p] > llSet) begin
                    lockLoss[p] <= 1'b1;
                end else if (lockErr[p] < llClr) begin
                    lockLoss[p] <= 1'b0;
                end
            end
        end
    end

    // alert pins: four-bit source code per pin, unused codes drive low
    always_ff @(posedge clk) begin
        if (srst) begin
            alertPin <= 4'h0;
        end else if (clkEn) begin
            for (int k = 0; k < 4; k++) begin
                case (alertCfg[4*k +: 4])
                    4'h0, 4'h1, 4'h2, 4'h3: alertPin[k] <= lossFlag[alertCfg[4*k +: 2]];
                    4'h4, 4'h5, 4'h6, 4'h7: alertPin[k] <= lockLoss[alertCfg[4*k +: 2]];
                    ALS_ANY_CL:            alertPin[k] <= |lossFlag;
                    ALS_ANY_LL:            alertPin[k] <= |lockLoss;
                    default:               alertPin[k] <= 1'b0;
                endcase
            end
        end
    end
endmodule : icm_monitor

/* File: verilog/icm_pkg.sv */
// package of constants and types for the input clock monitor and switchover block
package icm_pkg;

    // ******************************************************************
    // sizes and timing
    // ******************************************************************
    localparam int  NUM_IN        = 4;
    localparam int  NUM_PLL       = 4;
    localparam int  DW            = 32;
    localparam int  AW            = 8;
    localparam int  FW            = 32;              // pll frequency word width
    localparam int  CLK_HZ        = 125_000_000;
    localparam real HOLD_TICK_S   = 0.035;           // history sample period, seconds
    localparam int  HOLD_TICK_CYC = int'($floor(HOLD_TICK_S * CLK_HZ));
    localparam int  HIST_AW       = 12;              // history depth 4096 ticks

    // ppm scaling: offset/expected*1e6 against threshold steps
    localparam logic [23:0] FINE_PPM_SCALE   = 24'd500000;  // 1e6 / 2 ppm step
    localparam logic [23:0] COARSE_PPM_SCALE = 24'd10000;   // 1e6 / 100 ppm step

    // ******************************************************************
    // register offsets
    // ******************************************************************
    localparam logic [AW-1:0] ADR_GLOBAL  = 8'h00;
    localparam logic [AW-1:0] ADR_ALERT   = 8'h04;
    localparam logic [AW-1:0] ADR_STAT    = 8'h08;
    localparam logic [AW-1:0] ADR_PLLSTAT = 8'h0C;
    localparam logic [AW-1:0] ADR_INPER   = 8'h10;   // +4*input
    localparam logic [AW-1:0] ADR_INTHR   = 8'h20;   // +4*input
    localparam logic [AW-1:0] ADR_INEXP   = 8'h30;   // +4*input
    localparam logic [AW-1:0] ADR_PLLCFG  = 8'h40;   // +4*pll
    localparam logic [AW-1:0] ADR_HOLDF   = 8'h50;   // +4*pll

    // ******************************************************************
    // field layouts
    // ******************************************************************
    typedef struct packed {
        logic [23:0] rsvd;
        logic [2:0]  llSel;      // lock-loss threshold pair
        logic [2:0]  goldSel;    // 0..3 input, 4..7 reference
        logic [1:0]  lossSel;    // 2/4/8/16 missing pulses
    } icm_global_t;

    typedef struct packed {
        logic [5:0]  rsvd;
        logic [9:0]  holdDelay;  // ticks skipped before averaging
        logic [3:0]  holdExp;    // averaging window = 2**holdExp ticks
        logic        trigDrift;  // switch on loss or drift
        logic        revert;
        logic [1:0]  spares;     // spares ranked after entry 0
        logic [7:0]  prio;       // entry j in bits 2j+1:2j, entry 0 active
    } icm_pll_cfg_t;

    typedef struct packed {
        logic        holdover;
        logic [1:0]  active;
    } icm_pll_stat_t;

    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [DW-1:0] RST_GLOBAL = 32'h0000_0001;
    localparam logic [DW-1:0] RST_ALERT  = 32'h0000_FFFF;
    localparam logic [DW-1:0] RST_INPER  = 32'h0001_0100;
    localparam logic [DW-1:0] RST_INTHR  = 32'h0000_0532;
    localparam logic [DW-1:0] RST_INEXP  = 32'h0000_1000;
    localparam logic [DW-1:0] RST_PLLCFG = 32'h000E_57E4;

    // lock-loss set/clear pairs in 0.1 ppm units
    localparam logic [15:0] LL_SET_TBL [5] = '{16'h0004, 16'h0028, 16'h0190,
                                               16'h0FA0, 16'h9C40};
    localparam logic [15:0] LL_CLR_TBL [5] = '{16'h0002, 16'h0014, 16'h00C8,
                                               16'h07D0, 16'h4E20};

    // alert pin source codes
    localparam logic [3:0] ALS_LL_BASE = 4'h4;
    localparam logic [3:0] ALS_ANY_CL  = 4'h8;
    localparam logic [3:0] ALS_ANY_LL  = 4'h9;

endpackage : icm_pkg

/* File: dv/icm_clk_src.sv */
// model of the four external input clock sources
`timescale 1ns/100ps
module icm_clk_src (
    input  wire logic       clk,
    input  wire logic [3:0] run,
    output logic      [3:0] inClk = 4'h0
);
    logic [3:0] cnt = 4'h0;
    // 20-cycle period; a stopped source parks low like a dead oscillator
    always_ff @(posedge clk) begin
        cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
        inClk <= run & ((cnt == 4'h9) ? ~inClk : inClk);
    end
endmodule : icm_clk_src

/* File: dv/icm_monitor_props.sv */
// port checker for the clock monitor top
`timescale 1ns/100ps
module icm_monitor_props (
    input  wire logic                         clk,
    input  wire logic                         srst,
    input  wire logic                         clkEn,
    input  wire logic [icm_pkg::AW-1:0]       regAddr,
    input  wire logic                         regRd,
    input  wire logic [icm_pkg::DW-1:0]       regRdData,
    input  icm_pkg::icm_pll_stat_t [3:0]      pllStat,
    input  wire logic [3:0][icm_pkg::FW-1:0]  holdFreq,
    input  wire logic [3:0]                   alertPin
);
    import icm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic rdHole;
    // read of a hole in the map, seen one cycle later
    always_ff @(posedge clk) begin
        rdHole <= !srst && clkEn && regRd && regAddr == 8'hFC;
    end
    a_rd_idle: assert property ($past(clkEn) && !$past(regRd) |-> regRdData == '0)
        else $error("read data not cleared");
    a_rd_hole: assert property (rdHole |-> regRdData == '0)
        else $error("unmapped read not zero");
    a_hold_frozen0: assert property (pllStat[0].holdover [*2] |-> $stable(holdFreq[0]))
        else $error("holdover frequency moved");
    a_hold_frozen1: assert property (pllStat[1].holdover [*2] |-> $stable(holdFreq[1]))
        else $error("holdover frequency moved");
    a_freeze_stat: assert property (!$past(clkEn) |-> $stable(pllStat))
        else $error("status moved while frozen");
    a_freeze_alert: assert property (!$past(clkEn) |-> $stable(alertPin))
        else $error("alert moved while frozen");
    a_freeze_hold: assert property (!$past(clkEn) |-> $stable(holdFreq))
        else $error("hold value moved while frozen");
    a_freeze_rd: assert property (!$past(clkEn) |-> $stable(regRdData))
        else $error("read data moved while frozen");
endmodule : icm_monitor_props
bind icm_monitor icm_monitor_props u_props (.clk(clk), .srst(srst), .clkEn(clkEn),
    .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .pllStat(pllStat),
    .holdFreq(holdFreq), .alertPin(alertPin));

/* File: dv/icm_monitor_test.sv */
// self-checking bench for the clock monitor top
`timescale 1ns/100ps
module icm_monitor_test;
    import icm_pkg::*;
    logic                clk = 1'b0, srst = 1'b1, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [3:0]          run = 4'hF, inClk, alertPin;
    logic [AW-1:0]       regAddr = '0;
    logic [DW-1:0]       regWrData = '0, regRdData, d;
    icm_pll_stat_t [3:0] pllStat;
    logic [3:0][FW-1:0]  holdFreq;
    logic [3:0][15:0]    lockErr = '0;
    int                  errTotal = 0, nCompared = 0, cyc = 0;
    // ************************************
    // clock, timeout, design and sources
    // ************************************
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errTotal++;
            give_verdict();
        end
    end
    icm_clk_src u_icm_clk_src (.clk(clk), .run(run), .inClk(inClk));
    // short gates and ticks keep the run brief
    icm_monitor #(.FINE_GATE_EDGES(16), .COARSE_SHIFT(2), .HOLD_TICK(8)) u_icm_monitor (
        .clk(clk), .srst(srst), .clkEn(clkEn), .inClk(inClk), .refClk(1'b0), .lockErr(lockErr),
        .freqWord({4{32'h0000_1234}}), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pllStat(pllStat),
        .holdFreq(holdFreq), .alertPin(alertPin));
    // ************************************
    // access and compare tasks
    // ************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    // data sampled mid-cycle, well after the answering edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask : rd
    task automatic give_verdict();
        if (errTotal == 0 && nCompared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // ************************************
    // main sequence
    // ************************************
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd(ADR_GLOBAL);
        chk(d, RST_GLOBAL);
        rd(ADR_PLLCFG);
        chk(d, RST_PLLCFG);
        rd(8'hFC);
        chk(d, 32'h0);
        for (int i = 0; i < 4; i++) wr(ADR_INPER + 8'(4 * i), 32'h0001_001E);
        wr(ADR_PLLCFG + 8'h04, 32'h000E_53E4);
        wr(ADR_PLLCFG + 8'h08, 32'h000E_571B);
        wr(ADR_ALERT, 32'h0000_0058);
        // lock error 0.5, 0.3, 0.1 ppm: set above 0.4, hold, clear below 0.2
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) lockErr[1] <= 16'(5 - 2 * i);
            repeat (3) @(negedge clk);
            chk(alertPin[1], 32'(i < 2));
        end
        repeat (100) @(negedge clk);
        chk(pllStat[2].active, 32'h3);
        // input 0 dies: pll0 and pll1 move to entry 1
        run = 4'hE;
        repeat (400) @(negedge clk);
        chk(pllStat[0].active, 32'h1);
        chk(pllStat[1].active, 32'h1);
        chk(alertPin[0], 32'h1);
        rd(ADR_STAT);
        chk(d[3:0], 32'h1);
        chk(d[11:4], 32'hE0);
        @(posedge clk) clkEn <= 1'b0;
        repeat (3) @(posedge clk);
        clkEn <= 1'b1;
        run <= 4'hF;
        repeat (100) @(negedge clk);
        chk(pllStat[0].active, 32'h0);
        chk(pllStat[1].active, 32'h1);
        run = 4'h0;
        repeat (400) @(negedge clk);
        chk(pllStat[0].holdover, 32'h1);
        chk(holdFreq[0], 32'h0000_1234);
        // input 3 golden; input 1 expects its true 16 edges per window
        wr(ADR_GLOBAL, 32'h0000_000D);
        wr(ADR_INEXP + 8'h04, 32'h0000_0010);
        run <= 4'hF;
        repeat (700) @(negedge clk);
        rd(ADR_STAT);
        chk(d[15:0], 32'h0000_0550);
        chk(pllStat[0].active, 32'h0);
        // drift now counts for pll3 only, so it leaves drifting input 0
        wr(ADR_PLLCFG + 8'h0C, 32'h000E_5FE4);
        repeat (4) @(negedge clk);
        chk(pllStat[3].active, 32'h1);
        give_verdict();
    end
endmodule : icm_monitor_test
